// ### common/scrp_consts.vh
// Constants for the serial control-register port.
`ifndef SCRP_CONSTS_VH
`define SCRP_CONSTS_VH
`define SCRP_PKT_BITS      5'd16
`define SCRP_FRAME_PATTERN 8'hf0
`define SCRP_OP_READ       4'h0
`define SCRP_OP_WRITE      4'h1
`define SCRP_OP_SETRST     4'h2
`define SCRP_OP_FAST       4'h4
`define SCRP_OP_CLRRST     4'hb
`define SCRP_OP_NOP        4'hf
`define SCRP_ADDR_INIT     12'h021
`define SCRP_INIT_RESET    16'h00bf
`define SCRP_INIT_ID_LSB   0
`define SCRP_INIT_ID_MSB   5
`define SCRP_INIT_SKIP_BIT 7
`define SCRP_NUM_REGS      4
`define SCRP_REG_RESET     16'h0000
`define SCRP_APB_CTRL      12'h000
`define SCRP_APB_STAT      12'h004
`define SCRP_APB_DATA      12'h008
`define SCRP_APB_INIT      12'h00c
`endif

// ### design/scrp_serial_port.v
// Serial control-register port with APB observation registers.
// Operation
// - Repeat chain data, read data reversed.
// - Read and write transactions are four sixteen-bit packets.
// - Data bits captured on falling clock edge.
// - Request framed by 11110000 on both edges.
// - Select matches chain identifier field.
// - Broadcast flag selects every device.
// - Address packet picks the control register.
// - Write order request address data interval.
// - Read order request address interval data.
// - Request packet field positions by cycle.
// - Address and data packet field positions.
// - Opcode decode of read write reset fast.
// - Assert reset returns registers to reset.
// - Release reset clears bit, values kept.
// - Fast clock command sets fast mode.
// - Reset and fast commands are one packet.
// - Interface reset sets init register state.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "scrp_consts.vh"
`default_nettype none
module scrp_serial_port (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        clk_en,
    input  wire        ser_clk,
    input  wire        cmd_in,
    input  wire        chain_in_pin_i,
    output wire        chain_in_pin_o,
    output wire        chain_in_pin_oe,
    input  wire        chain_out_pin_i,
    output wire        chain_out_pin_o,
    output wire        chain_out_pin_oe,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr
);
    localparam ST_IDLE = 3'd0;
    localparam ST_REQ  = 3'd1;
    localparam ST_ADDR = 3'd2;
    localparam ST_WDAT = 3'd3;
    localparam ST_WINT = 3'd4;
    localparam ST_RINT = 3'd5;
    localparam ST_RDAT = 3'd6;

    reg  [2:0]  sckSync_reg;
    reg  [2:0]  cmdSync_reg;
    reg  [2:0]  inSync_reg;
    reg  [2:0]  outSync_reg;
    reg         sckLevel_reg;
    reg         cmdLevel_reg;
    reg         inLevel_reg;
    reg         outLevel_reg;
    reg  [7:0]  frame_reg;
    reg  [2:0]  state_reg;
    reg  [3:0]  bitCnt_reg;
    reg  [15:0] shift_reg;
    reg  [3:0]  opcode_reg;
    reg         bcast_reg;
    reg  [5:0]  devSel_reg;
    reg  [11:0] regAddr_reg;
    reg  [15:0] initReg_reg;
    reg  [15:0] regs_reg [0:`SCRP_NUM_REGS-1];
    reg  [15:0] rdShift_reg;
    reg         resetBit_reg;
    reg         fastMode_reg;
    reg         passEnable_reg;
    reg         rdDrive_reg;
    reg  [7:0]  txnCount_reg;
    reg  [3:0]  lastOp_reg;

    wire        sckRise;
    wire        sckFall;
    wire        selected;
    wire        isInit;
    wire [15:0] pktWord;
    wire [1:0]  regIdx;
    wire        apbAccess;
    wire [15:0] rdValue;
    integer     i;

    assign sckRise = clk_en & (sckSync_reg[2] == sckSync_reg[1])
                     & sckSync_reg[2] & ~sckLevel_reg;
    assign sckFall = clk_en & (sckSync_reg[2] == sckSync_reg[1])
                     & ~sckSync_reg[2] & sckLevel_reg;
    assign pktWord = {shift_reg[14:0], inLevel_reg};
    assign selected = bcast_reg
        | (devSel_reg == initReg_reg[`SCRP_INIT_ID_MSB:`SCRP_INIT_ID_LSB]);
    assign isInit = (regAddr_reg == `SCRP_ADDR_INIT);
    assign regIdx = regAddr_reg[1:0];
    assign rdValue = isInit ? initReg_reg : regs_reg[regIdx];

    // Forward traffic passes down the chain; read data goes back up.
    assign chain_out_pin_o  = inLevel_reg;
    // The downstream pin is released while the read packet travels back.
    assign chain_out_pin_oe = passEnable_reg & ~chain_in_pin_oe;
    assign chain_in_pin_o   = rdDrive_reg ? rdShift_reg[15] : outLevel_reg;
    assign chain_in_pin_oe  = rdDrive_reg | (state_reg == ST_RDAT);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sckSync_reg  <= 3'h0;
            cmdSync_reg  <= 3'h0;
            inSync_reg   <= 3'h0;
            outSync_reg  <= 3'h0;
            sckLevel_reg <= 1'b0;
            cmdLevel_reg <= 1'b0;
            inLevel_reg  <= 1'b0;
            outLevel_reg <= 1'b0;
        end else if (clk_en) begin
            sckSync_reg <= {sckSync_reg[1:0], ser_clk};
            cmdSync_reg <= {cmdSync_reg[1:0], cmd_in};
            inSync_reg  <= {inSync_reg[1:0], chain_in_pin_i};
            outSync_reg <= {outSync_reg[1:0], chain_out_pin_i};
            if (sckSync_reg[2] == sckSync_reg[1]) begin
                sckLevel_reg <= sckSync_reg[2];
            end
            if (cmdSync_reg[2] == cmdSync_reg[1]) begin
                cmdLevel_reg <= cmdSync_reg[2];
            end
            if (inSync_reg[2] == inSync_reg[1]) begin
                inLevel_reg <= inSync_reg[2];
            end
            if (outSync_reg[2] == outSync_reg[1]) begin
                outLevel_reg <= outSync_reg[2];
            end
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_reg      <= 8'h00;
            state_reg      <= ST_IDLE;
            bitCnt_reg     <= 4'h0;
            shift_reg      <= 16'h0000;
            opcode_reg     <= `SCRP_OP_NOP;
            bcast_reg      <= 1'b0;
            devSel_reg     <= 6'h00;
            regAddr_reg    <= 12'h000;
            initReg_reg    <= `SCRP_INIT_RESET;
            rdShift_reg    <= 16'h0000;
            resetBit_reg   <= 1'b0;
            fastMode_reg   <= 1'b0;
            passEnable_reg <= 1'b1;
            rdDrive_reg    <= 1'b0;
            txnCount_reg   <= 8'h00;
            lastOp_reg     <= `SCRP_OP_NOP;
            for (i = 0; i < `SCRP_NUM_REGS; i = i + 1) begin
                regs_reg[i] <= `SCRP_REG_RESET;
            end
        end else if (sckRise | sckFall) begin
            frame_reg <= {frame_reg[6:0], cmdLevel_reg};
            if ((state_reg == ST_IDLE) &&
                ({frame_reg[6:0], cmdLevel_reg} == `SCRP_FRAME_PATTERN)) begin
                state_reg  <= ST_REQ;
                bitCnt_reg <= 4'h0;
            end
            if (sckFall && (state_reg != ST_IDLE)) begin
                shift_reg  <= pktWord;
                bitCnt_reg <= bitCnt_reg + 4'h1;
                if (state_reg == ST_RDAT) begin
                    rdShift_reg <= {rdShift_reg[14:0], 1'b0};
                end
                if (bitCnt_reg == 4'hf) begin
                    case (state_reg)
                        ST_REQ: begin
                            opcode_reg <= pktWord[9:6];
                            bcast_reg  <= pktWord[5];
                            devSel_reg <= {pktWord[10], pktWord[4:0]};
                            lastOp_reg <= pktWord[9:6];
                            case (pktWord[9:6])
                                `SCRP_OP_READ: state_reg <= ST_ADDR;
                                `SCRP_OP_WRITE: state_reg <= ST_ADDR;
                                `SCRP_OP_SETRST: begin
                                    state_reg <= ST_IDLE;
                                    if (pktWord[5] | ({pktWord[10],
                                        pktWord[4:0]} == initReg_reg[5:0]))
                                    begin
                                        resetBit_reg <= 1'b1;
                                        initReg_reg  <= `SCRP_INIT_RESET;
                                        for (i = 0; i < `SCRP_NUM_REGS;
                                             i = i + 1) begin
                                            regs_reg[i] <= `SCRP_REG_RESET;
                                        end
                                    end
                                end
                                `SCRP_OP_CLRRST: begin
                                    state_reg    <= ST_IDLE;
                                    resetBit_reg <= 1'b0;
                                end
                                `SCRP_OP_FAST: begin
                                    state_reg    <= ST_IDLE;
                                    fastMode_reg <= 1'b1;
                                end
                                default: state_reg <= ST_IDLE;
                            endcase
                        end
                        ST_ADDR: begin
                            regAddr_reg <= pktWord[11:0];
                            state_reg <= (opcode_reg == `SCRP_OP_WRITE) ?
                                         ST_WDAT : ST_RINT;
                        end
                        ST_WDAT: begin
                            state_reg <= ST_WINT;
                            if (selected && !resetBit_reg) begin
                                if (isInit) begin
                                    initReg_reg <= pktWord;
                                end else begin
                                    regs_reg[regIdx] <= pktWord;
                                end
                            end
                        end
                        ST_WINT: begin
                            state_reg    <= ST_IDLE;
                            txnCount_reg <= txnCount_reg + 8'h01;
                        end
                        ST_RINT: begin
                            state_reg   <= ST_RDAT;
                            rdShift_reg <= rdValue;
                            rdDrive_reg <= selected;
                        end
                        ST_RDAT: begin
                            state_reg    <= ST_IDLE;
                            rdDrive_reg  <= 1'b0;
                            txnCount_reg <= txnCount_reg + 8'h01;
                        end
                        default: state_reg <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    assign apbAccess = psel & penable;
    assign pready    = 1'b1;
    assign pslverr   = apbAccess & ~pwrite & (paddr != `SCRP_APB_CTRL) &
                       (paddr != `SCRP_APB_STAT) & (paddr != `SCRP_APB_DATA) &
                       (paddr != `SCRP_APB_INIT);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            case (paddr)
                `SCRP_APB_CTRL: prdata <= {28'h0000000, lastOp_reg};
                `SCRP_APB_STAT: prdata <= {16'h0000, txnCount_reg,
                                           1'b0, state_reg, rdDrive_reg,
                                           passEnable_reg, fastMode_reg,
                                           resetBit_reg};
                `SCRP_APB_DATA: prdata <= {20'h00000, regAddr_reg};
                `SCRP_APB_INIT: prdata <= {16'h0000, initReg_reg};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### verification/scrp_port_checker.sv
// Assertion checker for the serial control-register port.
`timescale 1ns/10ps
`default_nettype none
module scrp_port_checker (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        chain_in_pin_i,
    input wire logic        chain_in_pin_o,
    input wire logic        chain_in_pin_oe,
    input wire logic        chain_out_pin_i,
    input wire logic        chain_out_pin_o,
    input wire logic        chain_out_pin_oe
);
    logic [7:0] oeCnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) oeCnt <= 8'h00;
        else oeCnt <= chain_in_pin_oe ? oeCnt + 8'h01 : 8'h00;
    end
    AST_OE_EXCL: assert property (chain_in_pin_oe |-> !chain_out_pin_oe)
        else $error("Both chain pins driven.");
    AST_OUT_DRIVE: assert property (!chain_in_pin_oe |-> chain_out_pin_oe)
        else $error("Downstream pin released while idle.");
    AST_FWD: assert property ($changed(chain_in_pin_i) && chain_out_pin_oe
        |-> ##[1:6] (chain_out_pin_o == chain_in_pin_i))
        else $error("Downstream repeat missing.");
    AST_BACK: assert property ($changed(chain_out_pin_i) && !chain_in_pin_oe
        |-> ##[1:6] (chain_in_pin_o == chain_out_pin_i))
        else $error("Upstream repeat missing.");
    AST_RD_HOLD: assert property ($rose(chain_in_pin_oe) |-> chain_in_pin_oe[*8])
        else $error("Read drive too short.");
    AST_RD_SPAN: assert property ($fell(chain_in_pin_oe) |->
        oeCnt >= 8'd124 && oeCnt <= 8'd132)
        else $error("Read drive not one packet long.");
    AST_RST_ST: assert property ($rose(rst_n) |-> chain_out_pin_oe && !chain_in_pin_oe)
        else $error("Pin drive wrong after reset.");
    AST_ERR_DATA: assert property (pslverr |-> psel && penable && prdata == 32'h0)
        else $error("Error response malformed.");
endmodule
bind scrp_serial_port scrp_port_checker scrp_port_checker_i (.sys_clk, .rst_n,
    .psel, .penable, .pslverr, .prdata, .chain_in_pin_i, .chain_in_pin_o,
    .chain_in_pin_oe, .chain_out_pin_i, .chain_out_pin_o, .chain_out_pin_oe);
`default_nettype wire

// ### verification/scrp_ctl_model.sv
// Controller model driving the serial link of the port.
`timescale 1ns/10ps
`default_nettype none
module scrp_ctl_model (
    output var logic ser_clk,
    output var logic cmd_in,
    output var logic ctlDat,
    input  wire logic rdBit
);
    initial begin
        ser_clk = 1'b0;
        cmd_in = 1'b0;
        ctlDat = 1'b0;
    end
    task automatic cyc(input logic c, input logic d, output logic q);
        ser_clk = 1'b1;
        #20 cmd_in = c;
        ctlDat = d;
        #20 ser_clk = 1'b0;
        q = rdBit;
        #40;
    endtask
    task automatic xfer(input logic [3:0] op, input logic bc,
            input logic [5:0] dev, input logic [11:0] a,
            input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] pk;
        logic        q;
        int          n;
        int          i;
        pk = {5'h0, dev[5], op, bc, dev[4:0], 4'h0, a, 32'h0};
        if (op == 4'h1) pk[31:16] = wd;
        n = (op < 4'h2) ? 64 : 16;
        rd = 16'h0;
        for (i = 0; i < 4; i++) cyc(i < 2, 1'b0, q);
        for (i = 0; i < n; i++) begin
            if (op == 4'h0 && i >= 48) cyc(1'b0, ~ctlDat, q);
            else cyc(1'b0, pk[63 - i], q);
            if (i >= 48) rd[63 - i] = q;
        end
        for (i = 0; i < 16; i++) cyc(1'b0, 1'b0, q);
    endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking testbench for the serial control-register port.
`timescale 1ns/10ps
`include "scrp_consts.vh"
`default_nettype none
module tb;
    logic        sys_clk, rst_n, psel, penable, pwrite, sawOe, re, clkEn;
    logic [11:0] paddr;
    logic [31:0] pwdata, rv;
    logic [15:0] rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, ser_clk, cmd_in, ctlDat;
    wire         chain_in_pin_i, chain_in_pin_o, chain_in_pin_oe;
    wire         chain_out_pin_i, chain_out_pin_o, chain_out_pin_oe;
    int          numErrors, testsRun;
    assign chain_in_pin_i = chain_in_pin_oe ? chain_in_pin_o : ctlDat;
    assign chain_out_pin_i = chain_out_pin_oe ? chain_out_pin_o : 1'b1;
    scrp_serial_port scrp_serial_port_i (.sys_clk, .rst_n, .clk_en(clkEn),
        .ser_clk, .cmd_in, .chain_in_pin_i, .chain_in_pin_o, .chain_in_pin_oe,
        .chain_out_pin_i, .chain_out_pin_o, .chain_out_pin_oe, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    scrp_ctl_model scrp_ctl_model_i (.ser_clk, .cmd_in, .ctlDat,
        .rdBit(chain_in_pin_i));
    always @(posedge sys_clk) if (chain_in_pin_oe) sawOe <= 1'b1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'h0000ffff;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) numErrors++;
    endtask
    task automatic xf(input logic [3:0] op, input logic bc, input logic [5:0] d,
            input logic [15:0] wd);
        scrp_ctl_model_i.xfer(op, bc, d, 12'h001, wd, rd);
    endtask
    task automatic t_reset;
        apb(1'b1, `SCRP_APB_INIT);
        apb(1'b0, `SCRP_APB_INIT);
        chk(rv, 32'h000000bf);
        apb(1'b0, 12'h010);
        chk({rv[30:0], re}, 32'h00000001);
        clkEn <= 1'b0;
        apb(1'b0, `SCRP_APB_INIT);
        chk(rv, 32'h00000000);
        clkEn <= 1'b1;
    endtask
    task automatic t_cmds;
        logic [3:0] ops[4] = '{4'h2, 4'hb, 4'h4, 4'hf};
        logic [1:0] st[4] = '{2'h1, 2'h0, 2'h2, 2'h2};
        foreach (ops[i]) begin
            scrp_ctl_model_i.xfer(ops[i], 1'b1, 6'h00, 12'h000, 16'h0, rd);
            apb(1'b0, `SCRP_APB_CTRL);
            chk(rv, {28'h0, ops[i]});
            apb(1'b0, `SCRP_APB_STAT);
            chk({30'h0, rv[1:0]}, {30'h0, st[i]});
        end
        apb(1'b0, `SCRP_APB_INIT);
        chk(rv, 32'h000000bf);
    endtask
    task automatic t_id;
        scrp_ctl_model_i.xfer(4'h1, 1'b1, 6'h2a, 12'h021, 16'h0005, rd);
        apb(1'b0, `SCRP_APB_INIT);
        chk(rv & 32'h3f, 32'h00000005);
        apb(1'b0, `SCRP_APB_DATA);
        chk(rv, 32'h00000021);
    endtask
    task automatic t_directed;
        xf(4'h1, 1'b0, 6'h05, 16'ha55a);
        sawOe = 1'b0;
        xf(4'h0, 1'b0, 6'h05, 16'h0);
        chk({16'h0, rd}, 32'h0000a55a);
        chk({31'h0, sawOe}, 32'h1);
        xf(4'h1, 1'b0, 6'h06, 16'h1234);
        xf(4'h0, 1'b0, 6'h06, 16'h0);
        chk({16'h0, rd}, 32'h0000ffff);
        xf(4'h0, 1'b0, 6'h05, 16'h0);
        chk({16'h0, rd}, 32'h0000a55a);
    endtask
    task automatic conclude;
        $display("Checks %0d errors %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #400000;
        numErrors++;
        conclude();
    end
    initial begin
        {rst_n, psel, penable, pwrite, sawOe, paddr, pwdata} = '0;
        clkEn = 1'b1;
        numErrors = 0;
        testsRun = 0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_cmds();
        t_id();
        t_directed();
        conclude();
    end
endmodule
`default_nettype wire
